// File: hdl/port_group_pkg.sv
/*
  Register map, field layout and function codes for the two eight-pin port groups.
  Assumes a 32-bit APB master; each 16-bit register sits in the low half of a word.
*/
package port_group_pkg;
  localparam int unsigned PINS      = 8;
  localparam int unsigned REG_W     = 16;
  localparam int unsigned ADDR_W    = 8;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

  // Byte offsets within the block
  localparam logic [7:0] OFF_G0_DATA   = 8'h00;
  localparam logic [7:0] OFF_G0_ENABLE = 8'h04;
  localparam logic [7:0] OFF_G0_PULL   = 8'h08;
  localparam logic [7:0] OFF_G0_FLAGS  = 8'h0C;
  localparam logic [7:0] OFF_G0_ICTL   = 8'h10;
  localparam logic [7:0] OFF_G0_DEB    = 8'h14;
  localparam logic [7:0] OFF_G0_MODE   = 8'h18;
  localparam logic [7:0] OFF_G0_FUNC   = 8'h1C;
  localparam logic [7:0] OFF_G1_DATA   = 8'h20;
  localparam logic [7:0] OFF_G1_ENABLE = 8'h24;
  localparam logic [7:0] OFF_G1_PULL   = 8'h28;
  localparam logic [7:0] OFF_G1_FLAGS  = 8'h2C;
  localparam logic [7:0] OFF_G1_ICTL   = 8'h30;
  localparam logic [7:0] OFF_G1_DEB    = 8'h34;
  localparam logic [7:0] OFF_G1_MODE   = 8'h38;
  localparam logic [7:0] OFF_G1_FUNC   = 8'h3C;
  localparam logic [7:0] OFF_SUMMARY   = 8'h40;

  // Upper and lower byte fields of the 16-bit registers
  localparam int unsigned HI_LSB = 8;
  localparam int unsigned LO_LSB = 0;

  typedef enum logic [1:0] {
    FUNC_0 = 2'b00,
    FUNC_1 = 2'b01,
    FUNC_2 = 2'b10,
    FUNC_3 = 2'b11
  } func_code_t;

  localparam int unsigned PIN_EXT_OSC   = 0;
  localparam int unsigned PIN_FRAME_OUT = 1;
  localparam int unsigned PIN_DET_IN    = 2;
endpackage

// File: hdl/pin_group.sv
/*
  One eight-pin group: GPIO pad control, edge detect and sticky flags.
  Assumes pad inputs synchronous to pclk; register state lives in the parent.
*/
`timescale 1ns/100ps
module pin_group
  import port_group_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [PINS-1:0]  pad_in,
  input  wire logic [PINS-1:0]  out_latch,
  input  wire logic [PINS-1:0]  pin_input_enable,
  input  wire logic [PINS-1:0]  pin_output_enable,
  input  wire logic [PINS-1:0]  pull_enable,
  input  wire logic [PINS-1:0]  pull_up_sel,
  input  wire logic [PINS-1:0]  pin_edge_select,
  input  wire logic [PINS-1:0]  pin_irq_enable,
  input  wire logic [PINS-1:0]  pin_mode_select,
  input  wire logic [PINS-1:0]  flag_clear,
  output logic      [PINS-1:0]  in_data,
  output logic      [PINS-1:0]  gpio_out,
  output logic      [PINS-1:0]  gpio_oe,
  output logic      [PINS-1:0]  pull_on,
  output logic      [PINS-1:0]  pull_up,
  output logic      [PINS-1:0]  pin_irq_flag,
  output logic                  group_irq_pending,
  output logic                  irq_request
);
  logic [PINS-1:0] prev_reg;
  logic [PINS-1:0] rise;
  logic [PINS-1:0] fall;
  logic [PINS-1:0] hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= pad_in;
    end
  end

  assign rise = pad_in & ~prev_reg;
  assign fall = ~pad_in & prev_reg;

  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      assign hit[i] = pin_edge_select[i] ? fall[i] : rise[i];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          in_data[i] <= 1'b0;
        end else begin
          in_data[i] <= pin_input_enable[i] & ~pin_mode_select[i] & pad_in[i];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_irq_flag[i] <= 1'b0;
        end else if (hit[i] && !pin_mode_select[i]) begin
          pin_irq_flag[i] <= 1'b1;
        end else if (flag_clear[i]) begin
          pin_irq_flag[i] <= 1'b0;
        end
      end

      assign gpio_out[i] = out_latch[i];
      assign gpio_oe[i]  = pin_output_enable[i] & ~pin_mode_select[i];
      assign pull_on[i]  = pull_enable[i] & ~pin_output_enable[i] & ~pin_mode_select[i];
      assign pull_up[i]  = pull_up_sel[i];
    end
  endgenerate

  assign group_irq_pending = |pin_irq_flag;
  assign irq_request = |(pin_irq_flag & pin_irq_enable);
endmodule

// File: hdl/port_group_gpio_config.sv
/*
  APB register file and function routing for port groups 0 and 1.
  Assumes APB3 master on pclk; pads and peripheral connections live outside.
*/
`timescale 1ns/100ps
module port_group_gpio_config
  import port_group_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [2*PINS-1:0]     pad_in,
  output logic      [2*PINS-1:0]     gpio_out,
  output logic      [2*PINS-1:0]     gpio_oe,
  output logic      [2*PINS-1:0]     pull_on,
  output logic      [2*PINS-1:0]     pull_up,
  output logic      [2*PINS-1:0]     periph_mode,
  output logic      [2*PINS-1:0]     debounce_on,
  output logic      [2*PINS*2-1:0]   pin_function_choice,
  output logic                       external_osc_input,
  output logic                       display_frame_sel,
  output logic                       detector_external_input,
  output logic      [PINS-1:0]       universal_pin_router_sel,
  output logic      [PINS-1:0]       universal_pin_router_in,
  output logic      [1:0]            group_irq_summary,
  output logic      [1:0]            irq_request
);
  import port_group_pkg::*;

  logic [REG_W-1:0] data_reg  [2];
  logic [REG_W-1:0] enab_reg  [2];
  logic [REG_W-1:0] pull_reg  [2];
  logic [REG_W-1:0] ictl_reg  [2];
  logic [PINS-1:0]  deb_reg   [2];
  logic [PINS-1:0]  mode_reg  [2];
  logic [REG_W-1:0] func_reg  [2];
  logic [PINS-1:0]  in_data   [2];
  logic [PINS-1:0]  flags     [2];
  logic [PINS-1:0]  clr       [2];
  logic [1:0]       pend;
  logic             wr_go;
  logic             rd_go;
  logic             hit;
  logic [31:0]      rd_next;
  logic [PINS-1:0]  pad0;

  assign wr_go = psel & penable & pwrite;
  assign rd_go = psel & penable & ~pwrite;
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  // Offsets split as group select (bit 5) and register within group (bits 4:2)
  function automatic logic [7:0] goff(input logic [7:0] base, input int g);
    goff = g[0] ? base + (OFF_G1_DATA - OFF_G0_DATA) : base;
  endfunction

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_grp
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          data_reg[g] <= REG_RESET;
        end else if (wr_go && paddr == goff(OFF_G0_DATA, g)) begin
          data_reg[g] <= {pwdata[HI_LSB +: PINS], data_reg[g][LO_LSB +: PINS]};
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          enab_reg[g] <= REG_RESET;
        end else if (wr_go && paddr == goff(OFF_G0_ENABLE, g)) begin
          enab_reg[g] <= pwdata[REG_W-1:0];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pull_reg[g] <= REG_RESET;
        end else if (wr_go && paddr == goff(OFF_G0_PULL, g)) begin
          pull_reg[g] <= pwdata[REG_W-1:0];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ictl_reg[g] <= REG_RESET;
        end else if (wr_go && paddr == goff(OFF_G0_ICTL, g)) begin
          ictl_reg[g] <= pwdata[REG_W-1:0];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          deb_reg[g] <= REG_RESET[PINS-1:0];
        end else if (wr_go && paddr == goff(OFF_G0_DEB, g)) begin
          deb_reg[g] <= pwdata[LO_LSB +: PINS];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode_reg[g] <= REG_RESET[PINS-1:0];
        end else if (wr_go && paddr == goff(OFF_G0_MODE, g)) begin
          mode_reg[g] <= pwdata[LO_LSB +: PINS];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          func_reg[g] <= REG_RESET;
        end else if (wr_go && paddr == goff(OFF_G0_FUNC, g)) begin
          func_reg[g] <= pwdata[REG_W-1:0];
        end
      end

      assign clr[g] = (wr_go && paddr == goff(OFF_G0_FLAGS, g)) ?
                      pwdata[LO_LSB +: PINS] : '0;

      // every pin outside peripheral mode gets GPIO and edge interrupt
      pin_group u_grp (
        .pclk              (pclk),
        .presetn           (presetn),
        .pad_in            (pad_in[g*PINS +: PINS]),
        .out_latch         (data_reg[g][HI_LSB +: PINS]),
        .pin_input_enable  (enab_reg[g][HI_LSB +: PINS]),
        .pin_output_enable (enab_reg[g][LO_LSB +: PINS]),
        .pull_enable       (pull_reg[g][LO_LSB +: PINS]),
        .pull_up_sel       (pull_reg[g][HI_LSB +: PINS]),
        .pin_edge_select   (ictl_reg[g][HI_LSB +: PINS]),
        .pin_irq_enable    (ictl_reg[g][LO_LSB +: PINS]),
        .pin_mode_select   (mode_reg[g]),
        .flag_clear        (clr[g]),
        .in_data           (in_data[g]),
        .gpio_out          (gpio_out[g*PINS +: PINS]),
        .gpio_oe           (gpio_oe[g*PINS +: PINS]),
        .pull_on           (pull_on[g*PINS +: PINS]),
        .pull_up           (pull_up[g*PINS +: PINS]),
        .pin_irq_flag      (flags[g]),
        .group_irq_pending (pend[g]),
        .irq_request       (irq_request[g])
      );

      assign periph_mode[g*PINS +: PINS] = mode_reg[g];
      assign debounce_on[g*PINS +: PINS] = deb_reg[g];
      for (genvar p = 0; p < PINS; p++) begin : g_fsel
        assign pin_function_choice[2*(g*PINS+p) +: 2] =
          mode_reg[g][p] ? func_reg[g][2*p +: 2] : FUNC_0;
      end
    end
  endgenerate

  assign group_irq_summary = pend;

  assign pad0 = pad_in[PINS-1:0];

  assign external_osc_input = mode_reg[0][PIN_EXT_OSC] &&
    func_code_t'(func_reg[0][2*PIN_EXT_OSC +: 2]) == FUNC_0 && pad0[PIN_EXT_OSC];
  assign display_frame_sel = mode_reg[0][PIN_FRAME_OUT] &&
    func_code_t'(func_reg[0][2*PIN_FRAME_OUT +: 2]) == FUNC_0;
  assign detector_external_input = mode_reg[0][PIN_DET_IN] &&
    func_code_t'(func_reg[0][2*PIN_DET_IN +: 2]) == FUNC_2 && pad0[PIN_DET_IN];

  generate
    for (g = 0; g < PINS; g++) begin : g_route
      assign universal_pin_router_sel[g] = mode_reg[0][g] &&
        func_code_t'(func_reg[0][2*g +: 2]) == FUNC_1;
      assign universal_pin_router_in[g] = universal_pin_router_sel[g] & pad0[g];
    end
  endgenerate

  always_comb begin
    hit     = 1'b1;
    rd_next = RD_ZERO;
    unique case (paddr)
      OFF_G0_DATA:   rd_next[REG_W-1:0] = {data_reg[0][HI_LSB +: PINS], in_data[0]};
      OFF_G0_ENABLE: rd_next[REG_W-1:0] = enab_reg[0];
      OFF_G0_PULL:   rd_next[REG_W-1:0] = pull_reg[0];
      OFF_G0_FLAGS:  rd_next[PINS-1:0]  = flags[0];
      OFF_G0_ICTL:   rd_next[REG_W-1:0] = ictl_reg[0];
      OFF_G0_DEB:    rd_next[PINS-1:0]  = deb_reg[0];
      OFF_G0_MODE:   rd_next[PINS-1:0]  = mode_reg[0];
      OFF_G0_FUNC:   rd_next[REG_W-1:0] = func_reg[0];
      OFF_G1_DATA:   rd_next[REG_W-1:0] = {data_reg[1][HI_LSB +: PINS], in_data[1]};
      OFF_G1_ENABLE: rd_next[REG_W-1:0] = enab_reg[1];
      OFF_G1_PULL:   rd_next[REG_W-1:0] = pull_reg[1];
      OFF_G1_FLAGS:  rd_next[PINS-1:0]  = flags[1];
      OFF_G1_ICTL:   rd_next[REG_W-1:0] = ictl_reg[1];
      OFF_G1_DEB:    rd_next[PINS-1:0]  = deb_reg[1];
      OFF_G1_MODE:   rd_next[PINS-1:0]  = mode_reg[1];
      OFF_G1_FUNC:   rd_next[REG_W-1:0] = func_reg[1];
      OFF_SUMMARY:   rd_next[1:0]       = pend;
      default:       hit = 1'b0;
    endcase
  end

  // Read data is combinational so it is valid in the single access cycle
  assign prdata  = rd_go ? rd_next : RD_ZERO;
  assign pslverr = psel & penable & ~hit;
endmodule

// File: dv/port_group_props.sv
/*
  Port-level checks for the two-group port block.
  Assumes pad_in is synchronous to pclk and held low during reset.
*/
`timescale 1ns/100ps
module port_group_props
  import port_group_pkg::*;
(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic [2*PINS-1:0]   pad_in,
  input wire logic [2*PINS-1:0]   gpio_oe,
  input wire logic [2*PINS-1:0]   pull_on,
  input wire logic [2*PINS-1:0]   periph_mode,
  input wire logic [2*PINS*2-1:0] pin_function_choice,
  input wire logic                external_osc_input,
  input wire logic                display_frame_sel,
  input wire logic                detector_external_input,
  input wire logic [PINS-1:0]     universal_pin_router_sel,
  input wire logic [PINS-1:0]     universal_pin_router_in,
  input wire logic [1:0]          group_irq_summary,
  input wire logic [1:0]          irq_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_req_needs_flag: assert property ((irq_request & ~group_irq_summary) == 2'b00)
    else $error("irq request without a pending flag");
  // Edge may be seen one or two cycles before the summary rises
  a_summary_cause: assert property ($rose(group_irq_summary[0]) |->
    ($past(pad_in[7:0]) != $past(pad_in[7:0], 2)) ||
    ($past(pad_in[7:0], 2) != $past(pad_in[7:0], 3)))
    else $error("summary rose without a pad edge");
  a_oe_not_mode: assert property ((gpio_oe & periph_mode) == '0)
    else $error("output enabled on a peripheral pin");
  a_pull_quiet: assert property ((pull_on & (gpio_oe | periph_mode)) == '0)
    else $error("pull active while driven or in peripheral mode");
  a_gpio_no_func: assert property (!periph_mode[0] |-> pin_function_choice[1:0] == 2'b00)
    else $error("function choice leaks in gpio mode");
  a_osc_route: assert property (external_osc_input ==
    (periph_mode[0] && pin_function_choice[1:0] == 2'b00 && pad_in[0]))
    else $error("oscillator input routing wrong");
  a_frame_route: assert property (display_frame_sel ==
    (periph_mode[1] && pin_function_choice[3:2] == 2'b00))
    else $error("frame output routing wrong");
  a_det_route: assert property (detector_external_input ==
    (periph_mode[2] && pin_function_choice[5:4] == 2'b10 && pad_in[2]))
    else $error("detector input routing wrong");
  a_router_sel: assert property (universal_pin_router_sel[0] ==
    (periph_mode[0] && pin_function_choice[1:0] == 2'b01))
    else $error("router select wrong");
  a_router_in: assert property (universal_pin_router_in ==
    (universal_pin_router_sel & pad_in[7:0]))
    else $error("router input not gated by select");
endmodule
bind port_group_gpio_config port_group_props i_props (.pclk(pclk), .presetn(presetn),
  .pad_in(pad_in), .gpio_oe(gpio_oe), .pull_on(pull_on), .periph_mode(periph_mode),
  .pin_function_choice(pin_function_choice), .external_osc_input(external_osc_input),
  .display_frame_sel(display_frame_sel), .detector_external_input(detector_external_input),
  .universal_pin_router_sel(universal_pin_router_sel),
  .universal_pin_router_in(universal_pin_router_in),
  .group_irq_summary(group_irq_summary), .irq_request(irq_request));

// File: dv/pad_model.sv
/*
  Pin-side model: external drivers plus loopback of driven outputs.
  Assumes the bench changes ext_lvl just after a pclk edge.
*/
`timescale 1ns/100ps
module pad_model
  import port_group_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic [2*PINS-1:0] ext_lvl,
  input  wire logic [2*PINS-1:0] gpio_out,
  input  wire logic [2*PINS-1:0] gpio_oe,
  output logic      [2*PINS-1:0] pad_in
);
  initial pad_in = '0;
  // a driven pin reads back its own latch
  always @(posedge pclk) begin
    pad_in <= (gpio_oe & gpio_out) | (~gpio_oe & ext_lvl);
  end
endmodule

// File: dv/testbench.sv
/*
  Self-checking bench: APB register tests, edge flags and pin routing.
  Assumes the designer's zero-wait APB slave and the pad model.
*/
`timescale 1ns/100ps
module testbench;
  import port_group_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [2*PINS-1:0] pad_in, ext_lvl, gpio_out, gpio_oe, periph_mode;
  logic [2*PINS-1:0] pull_on, pull_up, debounce_on;
  logic [4*PINS-1:0] func;
  logic              osc, frame, det;
  logic [PINS-1:0]   rsel, rin;
  logic [1:0]        summ, ireq;
  int                errors, checked;

  port_group_gpio_config i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .pull_on(pull_on), .pull_up(pull_up), .periph_mode(periph_mode),
    .debounce_on(debounce_on), .pin_function_choice(func), .external_osc_input(osc),
    .display_frame_sel(frame),
    .detector_external_input(det), .universal_pin_router_sel(rsel),
    .universal_pin_router_in(rin), .group_irq_summary(summ), .irq_request(ireq));
  pad_model i_pads (.pclk(pclk), .ext_lvl(ext_lvl), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .pad_in(pad_in));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("Counts: %0d checked, %0d errors", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One APB transfer; data and response are taken at the pready edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      print_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ext_lvl} = '0;
    errors = 0;
    checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 16; a++) begin
      xfer(1'b0, 8'(a * 4), '0);
      chk("reset value", rd, '0);
    end
    $display("reset test done");
    xfer(1'b1, OFF_G0_ENABLE, 32'h0000_FF00);
    ext_lvl <= 16'h00A5;
    repeat (3) @(posedge pclk);
    xfer(1'b1, OFF_G0_DATA, 32'hFFFF_5AFF);
    xfer(1'b0, OFF_G0_DATA, '0);
    chk("g0 data", rd, 32'h5AA5);
    chk("gpio_out", 32'(gpio_out), 32'h0000_005A);
    xfer(1'b1, OFF_G0_ENABLE, '0);
    xfer(1'b0, OFF_G0_DATA, '0);
    chk("input off", rd, 32'h5A00);
    xfer(1'b1, OFF_G0_ENABLE, 32'hFFFF);
    xfer(1'b0, OFF_G0_DATA, '0);
    chk("loopback", rd, 32'h5A5A);
    chk("gpio_oe", 32'(gpio_oe), 32'h0000_00FF);
    $display("data test done");
    xfer(1'b1, OFF_G0_ENABLE, '0);
    xfer(1'b1, OFF_G0_ICTL, 32'h0200);
    // reserved high bytes written as 0
    xfer(1'b1, OFF_G0_PULL, 32'h0000_C30F);
    xfer(1'b1, OFF_G0_DEB, 32'h0000_0033);
    chk("pull_on", 32'(pull_on), 32'h0000_000F);
    chk("pull_up", 32'(pull_up), 32'h0000_00C3);
    chk("debounce_on", 32'(debounce_on), 32'h0000_0033);
    xfer(1'b1, OFF_G0_FLAGS, 32'hFF);
    chk("summary clear", 32'(summ), '0);
    ext_lvl <= 16'h00A6;
    repeat (4) @(posedge pclk);
    xfer(1'b0, OFF_G0_FLAGS, '0);
    chk("wrong edges", rd, '0);
    ext_lvl <= 16'h01A5;
    repeat (4) @(posedge pclk);
    xfer(1'b0, OFF_G0_FLAGS, '0);
    chk("right edges", rd, 32'h03);
    chk("summary", 32'(summ), 32'h0000_0003);
    chk("no request", 32'(ireq), '0);
    xfer(1'b1, OFF_G0_ICTL, 32'h0203);
    chk("request", 32'(ireq), 32'h0000_0001);
    xfer(1'b1, OFF_G0_FLAGS, 32'h01);
    xfer(1'b0, OFF_G0_FLAGS, '0);
    chk("one cleared", rd, 32'h02);
    xfer(1'b1, OFF_G0_FLAGS, 32'h02);
    chk("g0 summary off", 32'(summ), 32'h0000_0002);
    xfer(1'b1, OFF_G1_FLAGS, 32'h01);
    xfer(1'b0, OFF_SUMMARY, '0);
    chk("summary reg", rd, '0);
    $display("interrupt test done");
    xfer(1'b1, OFF_G0_ENABLE, 32'h00FF);
    xfer(1'b1, OFF_G0_MODE, 32'h07);
    xfer(1'b1, OFF_G0_FUNC, 32'h0020);
    ext_lvl <= 16'h0005;
    repeat (3) @(posedge pclk);
    chk("oe in mode", 32'(gpio_oe), 32'h0000_00F8);
    chk("periph_mode", 32'(periph_mode), 32'h0000_0007);
    chk("pull off driven", 32'(pull_on), '0);
    chk("route f0 f2", 32'({osc, frame, det, rsel}), 32'h0000_0700);
    xfer(1'b1, OFF_G0_FUNC, 32'h0015);
    chk("route f1", 32'({osc, frame, det, rsel, rin}), 32'h0000_0705);
    xfer(1'b1, OFF_G0_MODE, '0);
    chk("gpio mode func", func, '0);
    chk("gpio mode route", 32'(rsel), '0);
    $display("routing test done");
    xfer(1'b1, 8'h44, 32'hFFFF);
    xfer(1'b0, 8'h44, '0);
    chk("unmapped error", 32'(err), 32'h0000_0001);
    chk("unmapped data", rd, '0);
    $display("unmapped test done");
    print_verdict;
  end
endmodule
